// ---- logic/mpgb_consts.svh ----
// constants for the multi-port gpio bank
`ifndef MPGB_CONSTS_SVH
`define MPGB_CONSTS_SVH

// port numbering
`define MPGB_NPORTS 6
`define MPGB_PORT_FIRST 4'h3
`define MPGB_PORT_LAST 4'h8
`define MPGB_PORT_INPUT_ONLY 4'h1
`define MPGB_IDX_P3 3'h0
`define MPGB_IDX_P4 3'h1
`define MPGB_IDX_P5 3'h2
`define MPGB_IDX_P6 3'h3

// reset values
`define MPGB_DIR_RESET 8'hFF
`define MPGB_LATCH_RESET 8'h00
`define MPGB_PU_RESET 8'h00
`define MPGB_SYNC_IDLE 8'hFF

// implemented pins per port
`define MPGB_MASK_P3 8'h7F
`define MPGB_MASK_P4 8'hFF
`define MPGB_MASK_P5 8'hFF
`define MPGB_MASK_P6 8'hF0
`define MPGB_MASK_P7 8'h3F
`define MPGB_MASK_P8 8'h01

// pins with a software pull-up
`define MPGB_PU_MASK_P3 8'h70

// port 3 alternate and led pins
`define MPGB_ALT_MASK_P3 8'h7C
`define MPGB_LED_MASK_P3 8'h0F

// port 6 expansion pin positions
`define MPGB_P6_RD_BIT 3
`define MPGB_P6_RD 4
`define MPGB_P6_WR 5
`define MPGB_P6_WAIT 6
`define MPGB_P6_ASTB 7
`define MPGB_P6_CTRL_MASK 8'hB0

`endif

// ---- logic/mpgb_pkg.sv ----
// types for the multi-port gpio bank
package mpgb_pkg;

   typedef enum logic [1:0] {
      MPGB_RD_PORT,
      MPGB_RD_DIR,
      MPGB_RD_PULLUP,
      MPGB_RD_NONE
   } mpgb_rd_kind_t;

   typedef struct packed {
      logic [3:0] port_sel;
      logic bit_mode;
      logic [2:0] bit_idx;
      logic [7:0] data;
   } mpgb_wr_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull;
   } mpgb_pins_t;

   typedef struct packed {
      logic [7:0] ad_out;
      logic ad_oe;
      logic [7:0] addr_hi;
      logic rd_n;
      logic wr_n;
      logic astb;
   } mpgb_exp_t;

endpackage

// ---- logic/mpgb_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
`include "mpgb_consts.svh"
module mpgb_sync import mpgb_pkg::*; #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] IDLE = '1
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // pins
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] stable
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= IDLE;
         stage2 <= IDLE;
         stage3 <= IDLE;
      end else begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit changes once stages two and three agree
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               stable[b] <= IDLE[b];
            end else if (stage2[b] == stage3[b]) begin
               stable[b] <= stage3[b];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ---- logic/mpgb_port_regs.sv ----
// direction, latch and pull-up registers of one port
`timescale 1ns/10ps
`default_nettype none
`include "mpgb_consts.svh"
module mpgb_port_regs import mpgb_pkg::*; #(
   parameter logic [7:0] IMPL_MASK = 8'hFF,
   parameter logic [7:0] PU_MASK = 8'hFF
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // cpu write side
   input wire logic sel,
   input wire logic latch_write_strobe,
   input wire logic dir_write_strobe,
   input wire logic pullup_write_strobe,
   input wire mpgb_wr_t wr,
   // register contents
   output logic [7:0] dir,
   output logic [7:0] latch,
   output logic [7:0] pull_en
);

   logic bit_ok;
   logic pu_bit_ok;

   assign bit_ok = IMPL_MASK[wr.bit_idx];
   assign pu_bit_ok = PU_MASK[wr.bit_idx];

   // direction register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dir <= `MPGB_DIR_RESET;
      end else if (sel && dir_write_strobe) begin
         if (wr.bit_mode) begin
            if (bit_ok) begin
               dir[wr.bit_idx] <= wr.data[0];
            end
         end else begin
            dir <= wr.data | ~IMPL_MASK;
         end
      end
   end

   // output latch
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         latch <= `MPGB_LATCH_RESET;
      end else if (sel && latch_write_strobe) begin
         if (wr.bit_mode) begin
            if (bit_ok) begin
               latch[wr.bit_idx] <= wr.data[0];
            end
         end else begin
            latch <= wr.data & IMPL_MASK;
         end
      end
   end

   // pull-up enables
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pull_en <= `MPGB_PU_RESET;
      end else if (sel && pullup_write_strobe) begin
         if (wr.bit_mode) begin
            if (pu_bit_ok) begin
               pull_en[wr.bit_idx] <= wr.data[0];
            end
         end else begin
            pull_en <= wr.data & PU_MASK;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   property p_dir_byte;
      sel && dir_write_strobe && !wr.bit_mode |=> dir == ($past(wr.data) | ~IMPL_MASK);
   endproperty
   a_dir_byte: assert property (p_dir_byte) else $error("byte write to direction lost");

   property p_dir_unimpl;
      (dir | IMPL_MASK) == 8'hFF;
   endproperty
   a_dir_unimpl: assert property (p_dir_unimpl) else $error("absent pin left output mode");

   property p_dir_bit_only;
      sel && dir_write_strobe && wr.bit_mode |=>
         ((dir ^ $past(dir)) & ~(8'h01 << $past(wr.bit_idx))) == 8'h00;
   endproperty
   a_dir_bit_only: assert property (p_dir_bit_only) else $error("bit write touched another bit");

endmodule
`default_nettype wire

// ---- logic/mpgb_bank.sv ----
// multi-port gpio bank, ports 3 to 8 with port 1 input path
//
// Behaviour
// - reset sets every direction register to all ones, pins in input mode
// - each direction register writes by single bit or whole byte
// - port 4 has eight pins with latch, direction and pull-up
// - port 5 has eight pins, becomes upper address bus in expansion
// - port 6 bits 4, 5 and 7 carry memory control outputs in expansion, bit 6 is the wait input
// - port 7 has six pins shared with timer, clock and buzzer outputs
// - port 8 has one pin shared with serial chip-select input
// - port 4 is multiplexed address and data bus in expansion
// - falling edge on any port 4 pin sets key-return flag
// - enabled pull-up on ports 4 to 6 stays on during expansion
// - wait pin of port 6 stays plain port when wait unused
// - port 3 bits 2 and 3 never get a pull-up
// - port 3 bits 2 to 6 serial alternates, bits 0 to 3 drive leds
// - pin level change in output mode still reaches the edge detector
// - port 1 is input only, no direction or latch
// - direction bit 0 drives the pin, 1 leaves it input
`timescale 1ns/10ps
`default_nettype none
`include "mpgb_consts.svh"
module mpgb_bank import mpgb_pkg::*; (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // cpu write side
   input wire mpgb_wr_t wr,
   input wire logic latch_write_strobe,
   input wire logic dir_write_strobe,
   input wire logic pullup_write_strobe,
   // cpu read side
   input wire logic [3:0] read_sel,
   input wire mpgb_rd_kind_t read_kind,
   output logic [7:0] read_data,
   // key-return flag
   input wire logic key_return_clear,
   output logic key_return_irq_flag,
   // expansion mode controls
   input wire logic exp_ad_en,
   input wire logic exp_addr_en,
   input wire logic exp_ctrl_en,
   input wire logic exp_wait_en,
   input wire mpgb_exp_t exp_bus,
   output logic [7:0] exp_ad_in,
   output logic exp_wait_level,
   // alternate function outputs and input levels, index 0 is port 3
   input wire logic [5:0][7:0] alt_en,
   input wire logic [5:0][7:0] alt_out,
   output logic [5:0][7:0] alt_in,
   // pins, index 0 is port 3
   input wire logic [5:0][7:0] pin_in,
   input wire logic [7:0] port1_in,
   output mpgb_pins_t [5:0] pin_drive
);

   localparam logic [5:0][7:0] IMPL = {`MPGB_MASK_P8, `MPGB_MASK_P7, `MPGB_MASK_P6,
                                       `MPGB_MASK_P5, `MPGB_MASK_P4, `MPGB_MASK_P3};
   localparam logic [5:0][7:0] PU_IMPL = {`MPGB_MASK_P8, `MPGB_MASK_P7, `MPGB_MASK_P6,
                                          `MPGB_MASK_P5, `MPGB_MASK_P4, `MPGB_PU_MASK_P3};

   logic rst_meta;
   logic rst_n;
   logic [5:0][7:0] dir;
   logic [5:0][7:0] latch;
   logic [5:0][7:0] pull_en;
   logic [5:0][7:0] level;
   logic [7:0] port1_level;
   logic [7:0] p4_prev;
   logic key_fall;
   logic [5:0][7:0] exp_take;
   mpgb_pins_t [5:0] next_pin_drive;
   logic [7:0] next_read_data;

   // reset release through two flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // pin synchronisers
   mpgb_sync #(
      .WIDTH(56),
      .IDLE({7{`MPGB_SYNC_IDLE}})
   ) u_sync (
      .clock(clock),
      .reset_n(rst_n),
      .raw({port1_in, pin_in}),
      .stable({port1_level, level})
   );

   // per-port registers
   genvar i;
   generate
      for (i = 0; i < `MPGB_NPORTS; i++) begin : g_port
         mpgb_port_regs #(
            .IMPL_MASK(IMPL[i]),
            .PU_MASK(PU_IMPL[i])
         ) u_regs (
            .clock(clock),
            .reset_n(rst_n),
            .sel(wr.port_sel == (`MPGB_PORT_FIRST + 4'(i))),
            .latch_write_strobe(latch_write_strobe),
            .dir_write_strobe(dir_write_strobe),
            .pullup_write_strobe(pullup_write_strobe),
            .wr(wr),
            .dir(dir[i]),
            .latch(latch[i]),
            .pull_en(pull_en[i])
         );
      end
   endgenerate

   // pins taken over by expansion mode
   always_comb begin
      exp_take = '0;
      exp_take[`MPGB_IDX_P4] = {8{exp_ad_en}};
      exp_take[`MPGB_IDX_P5] = {8{exp_addr_en}};
      exp_take[`MPGB_IDX_P6] = {8{exp_ctrl_en}} & `MPGB_P6_CTRL_MASK;
      exp_take[`MPGB_IDX_P6][`MPGB_P6_WAIT] = exp_wait_en;
   end

   // pin drive selection
   always_comb begin
      for (int p = 0; p < `MPGB_NPORTS; p++) begin
         next_pin_drive[p].oe = ~dir[p] & IMPL[p];
         next_pin_drive[p].out = ((alt_en[p] & alt_out[p]) | (~alt_en[p] & latch[p])) & IMPL[p];
         next_pin_drive[p].pull = pull_en[p] & PU_IMPL[p] & (dir[p] | exp_take[p]);
      end
      next_pin_drive[`MPGB_IDX_P3].out = ((alt_en[0] & alt_out[0] & `MPGB_ALT_MASK_P3)
                                         | (~(alt_en[0] & `MPGB_ALT_MASK_P3) & latch[0]))
                                         & `MPGB_MASK_P3;
      if (exp_ad_en) begin
         next_pin_drive[`MPGB_IDX_P4].out = exp_bus.ad_out;
         next_pin_drive[`MPGB_IDX_P4].oe = {8{exp_bus.ad_oe}};
      end
      if (exp_addr_en) begin
         next_pin_drive[`MPGB_IDX_P5].out = exp_bus.addr_hi;
         next_pin_drive[`MPGB_IDX_P5].oe = 8'hFF;
      end
      if (exp_ctrl_en) begin
         next_pin_drive[`MPGB_IDX_P6].out[`MPGB_P6_RD] = exp_bus.rd_n;
         next_pin_drive[`MPGB_IDX_P6].out[`MPGB_P6_WR] = exp_bus.wr_n;
         next_pin_drive[`MPGB_IDX_P6].out[`MPGB_P6_ASTB] = exp_bus.astb;
         next_pin_drive[`MPGB_IDX_P6].oe[`MPGB_P6_RD] = 1'b1;
         next_pin_drive[`MPGB_IDX_P6].oe[`MPGB_P6_WR] = 1'b1;
         next_pin_drive[`MPGB_IDX_P6].oe[`MPGB_P6_ASTB] = 1'b1;
      end
      if (exp_wait_en) begin
         next_pin_drive[`MPGB_IDX_P6].oe[`MPGB_P6_WAIT] = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_drive <= '0;
      end else begin
         pin_drive <= next_pin_drive;
      end
   end

   // levels toward expansion controller and alternate functions
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         exp_ad_in <= `MPGB_SYNC_IDLE;
         exp_wait_level <= 1'b1;
         alt_in <= '1;
      end else begin
         exp_ad_in <= level[`MPGB_IDX_P4];
         exp_wait_level <= level[`MPGB_IDX_P6][`MPGB_P6_WAIT];
         alt_in <= level & IMPL;
      end
   end

   // key-return falling edge detector, pin level seen in any direction
   assign key_fall = |(p4_prev & ~level[`MPGB_IDX_P4]);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         p4_prev <= `MPGB_SYNC_IDLE;
      end else begin
         p4_prev <= level[`MPGB_IDX_P4];
      end
   end

   // set wins over clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         key_return_irq_flag <= 1'b0;
      end else if (key_fall) begin
         key_return_irq_flag <= 1'b1;
      end else if (key_return_clear) begin
         key_return_irq_flag <= 1'b0;
      end
   end

   // read decode
   always_comb begin
      next_read_data = 8'h00;
      if (read_sel == `MPGB_PORT_INPUT_ONLY) begin
         if (read_kind == MPGB_RD_PORT) begin
            next_read_data = port1_level;
         end
      end else if (read_sel >= `MPGB_PORT_FIRST && read_sel <= `MPGB_PORT_LAST) begin
         for (int p = 0; p < `MPGB_NPORTS; p++) begin
            if (read_sel == (`MPGB_PORT_FIRST + 4'(p))) begin
               if (read_kind == MPGB_RD_PORT) begin
                  next_read_data = ((dir[p] & level[p]) | (~dir[p] & latch[p])) & IMPL[p];
               end else if (read_kind == MPGB_RD_DIR) begin
                  next_read_data = dir[p];
               end else if (read_kind == MPGB_RD_PULLUP) begin
                  next_read_data = pull_en[p];
               end
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         read_data <= 8'h00;
      end else begin
         read_data <= next_read_data;
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_p4_fall;
      key_fall;
   endsequence

   sequence s_flag_high;
      key_return_irq_flag;
   endsequence

   property p_key_set;
      s_p4_fall |=> s_flag_high;
   endproperty
   a_key_set: assert property (p_key_set) else $error("key-return flag missed an edge");

   property p_key_hold;
      key_return_irq_flag && !key_return_clear |=> key_return_irq_flag;
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("key-return flag dropped unasked");

   property p_key_quiet;
      !key_return_irq_flag && !key_fall |=> !key_return_irq_flag;
   endproperty
   a_key_quiet: assert property (p_key_quiet) else $error("key-return flag set with no edge");

   property p_input_mode_off;
      !exp_ad_en && !exp_addr_en && !exp_ctrl_en |=>
         (pin_drive[`MPGB_IDX_P3].oe & $past(dir[`MPGB_IDX_P3])) == 8'h00;
   endproperty
   a_input_mode_off: assert property (p_input_mode_off) else $error("input pin driving");

   property p_p3_no_pull;
      pin_drive[`MPGB_IDX_P3].pull[3:2] == 2'b00;
   endproperty
   a_p3_no_pull: assert property (p_p3_no_pull) else $error("pull-up on port 3 bit 2 or 3");

   property p_exp_pull_kept;
      exp_addr_en ##1 exp_addr_en |-> pin_drive[`MPGB_IDX_P5].pull == $past(pull_en[`MPGB_IDX_P5]);
   endproperty
   a_exp_pull_kept: assert property (p_exp_pull_kept) else $error("pull-up lost in expansion");

   property p_addr_bus;
      exp_addr_en |=> pin_drive[`MPGB_IDX_P5].oe == 8'hFF && pin_drive[`MPGB_IDX_P5].out == $past(exp_bus.addr_hi);
   endproperty
   a_addr_bus: assert property (p_addr_bus) else $error("upper address not driven");

   property p_wait_free;
      exp_ctrl_en && !exp_wait_en |=>
         pin_drive[`MPGB_IDX_P6].oe[`MPGB_P6_WAIT] == ~$past(dir[`MPGB_IDX_P6][`MPGB_P6_WAIT]);
   endproperty
   a_wait_free: assert property (p_wait_free) else $error("wait pin not a plain port");

   property p_port1_read;
      read_sel == `MPGB_PORT_INPUT_ONLY && read_kind != MPGB_RD_PORT |=> read_data == 8'h00;
   endproperty
   a_port1_read: assert property (p_port1_read) else $error("port 1 shows a register");

endmodule
`default_nettype wire

// ---- bench/mpgb_pins_model.sv ----
// external pin loads seen by the gpio bank
`timescale 1ns/10ps
`default_nettype none
module mpgb_pins_model import mpgb_pkg::*; (
   // clock
   input wire logic clock,
   // bank drive and bench loads
   input wire mpgb_pins_t [5:0] pin_drive,
   input wire logic [5:0][7:0] ext_en,
   input wire logic [5:0][7:0] ext_val,
   // resolved pin levels
   output logic [5:0][7:0] level
);
   logic flip = 1'b0;
   // undriven pins wander every cycle
   always @(posedge clock) begin
      flip <= ~flip;
   end
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         for (int b = 0; b < 8; b++) begin
            if (pin_drive[i].oe[b]) begin
               level[i][b] = pin_drive[i].out[b];
            end else if (ext_en[i][b]) begin
               level[i][b] = ext_val[i][b];
            end else if (pin_drive[i].pull[b]) begin
               level[i][b] = 1'b1;
            end else begin
               level[i][b] = flip ^ b[0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/mpgb_bank_tb.sv ----
// self-checking bench for the multi-port gpio bank
`timescale 1ns/10ps
`default_nettype none
`include "mpgb_consts.svh"
module mpgb_bank_tb import mpgb_pkg::*;;
   typedef struct {logic [5:0] src; logic [7:0] exp; string name;} mpgb_note_t;
   localparam logic [7:0] IMPL [6] = '{`MPGB_MASK_P3, `MPGB_MASK_P4, `MPGB_MASK_P5, `MPGB_MASK_P6,
      `MPGB_MASK_P7, `MPGB_MASK_P8};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   mpgb_wr_t wr = '0;
   logic st_latch = 1'b0, st_dir = 1'b0, st_pull = 1'b0, kr_clear = 1'b0, mon = 1'b0;
   logic [3:0] read_sel = 4'h0;
   mpgb_rd_kind_t read_kind = MPGB_RD_NONE;
   logic [7:0] read_data, exp_ad_in, d, l, p, e, m, pm;
   logic kr_flag, exp_wait_level;
   logic [3:0] exp_en = 4'h0;
   mpgb_exp_t exp_bus = '0;
   logic [5:0][7:0] alt_en = '0, alt_out = '0, alt_in, pin_in, ext_en = '1, ext_val = '1;
   logic [7:0] port1_in = 8'h00;
   mpgb_pins_t [5:0] pin_drive;
   mpgb_note_t notes[$];
   mpgb_note_t cur;
   int fail_count = 0, total_checks = 0, cycles = 0;
   logic [31:0] seed = 32'he6800c1b;

   mpgb_bank uut (.clock(clock), .reset_n(reset_n), .wr(wr), .latch_write_strobe(st_latch),
      .dir_write_strobe(st_dir), .pullup_write_strobe(st_pull), .read_sel(read_sel), .read_kind(read_kind),
      .read_data(read_data), .key_return_clear(kr_clear), .key_return_irq_flag(kr_flag),
      .exp_ad_en(exp_en[0]), .exp_addr_en(exp_en[1]), .exp_ctrl_en(exp_en[2]), .exp_wait_en(exp_en[3]),
      .exp_bus(exp_bus), .exp_ad_in(exp_ad_in), .exp_wait_level(exp_wait_level), .alt_en(alt_en),
      .alt_out(alt_out), .alt_in(alt_in), .pin_in(pin_in), .port1_in(port1_in), .pin_drive(pin_drive));
   mpgb_pins_model pins (.clock(clock), .pin_drive(pin_drive), .ext_en(ext_en), .ext_val(ext_val),
      .level(pin_in));

   always #5 clock = ~clock;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // observed value by source code
   function automatic logic [7:0] obs(input logic [5:0] src);
      case (src[5:3])
         3'h0: return (src[1:0] == 2'h0) ? read_data : (src[1:0] == 2'h1) ? {7'h00, kr_flag} :
            (src[1:0] == 2'h2) ? exp_ad_in : {7'h00, exp_wait_level};
         3'h1: return pin_drive[src[2:0]].oe;
         3'h2: return pin_drive[src[2:0]].out;
         3'h3: return pin_drive[src[2:0]].pull;
         default: return alt_in[src[2:0]];
      endcase
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // monitor takes the oldest note when a result is due
   always @(negedge clock) begin
      if (mon) begin
         cur = notes.pop_front();
         check(cur.name, obs(cur.src), cur.exp);
      end
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic look(input string name, input logic [5:0] src, input logic [7:0] exp);
      @(posedge clock);
      notes.push_back('{src, exp, name});
      mon <= 1'b1;
      @(posedge clock);
      mon <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] sel, input mpgb_rd_kind_t kind, input logic [7:0] exp);
      @(posedge clock);
      read_sel <= sel;
      read_kind <= kind;
      look("read_data", 6'h00, exp);
   endtask

   // kind 0 latch, 1 direction, 2 pull-up
   task automatic wrt(input int kind, input logic [3:0] port, input logic bm, input logic [2:0] idx,
      input logic [7:0] data);
      @(posedge clock);
      wr <= '{port, bm, idx, data};
      st_latch <= (kind == 0);
      st_dir <= (kind == 1);
      st_pull <= (kind == 2);
      @(posedge clock);
      st_latch <= 1'b0;
      st_dir <= 1'b0;
      st_pull <= 1'b0;
   endtask

   task automatic clr_flag;
      @(posedge clock);
      kr_clear <= 1'b1;
      @(posedge clock);
      kr_clear <= 1'b0;
   endtask

   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      for (int i = 0; i < 6; i++) begin
         rd(4'(i + 3), MPGB_RD_DIR, 8'hFF);
         rd(4'(i + 3), MPGB_RD_PULLUP, 8'h00);
         look("oe", 6'(8 + i), 8'h00);
      end
      // random byte writes on every port
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            {e, p, l, d} = seed;
            m = IMPL[i];
            pm = (i == 0) ? `MPGB_PU_MASK_P3 : m;
            ext_val[i] <= e;
            wrt(1, 4'(i + 3), 1'b0, 3'h0, d);
            wrt(0, 4'(i + 3), 1'b0, 3'h0, l);
            wrt(2, 4'(i + 3), 1'b0, 3'h0, p);
            repeat (8) @(posedge clock);
            look("oe", 6'(8 + i), ~d & m);
            look("pull", 6'(24 + i), p & pm & d);
            look("alt_in", 6'(32 + i), ((d & e) | (~d & l)) & m);
            rd(4'(i + 3), MPGB_RD_DIR, d | ~m);
            rd(4'(i + 3), MPGB_RD_PULLUP, p & pm);
            rd(4'(i + 3), MPGB_RD_PORT, ((d & e) | (~d & l)) & m);
         end
      end
      // single bit writes
      wrt(1, 4'h4, 1'b0, 3'h0, 8'hFF);
      wrt(1, 4'h4, 1'b1, 3'h5, 8'hFE);
      rd(4'h4, MPGB_RD_DIR, 8'hDF);
      wrt(1, 4'h8, 1'b0, 3'h0, 8'hFF);
      wrt(1, 4'h8, 1'b1, 3'h3, 8'h00);
      rd(4'h8, MPGB_RD_DIR, 8'hFF);
      wrt(2, 4'h3, 1'b0, 3'h0, 8'hFF);
      wrt(2, 4'h3, 1'b1, 3'h2, 8'h01);
      rd(4'h3, MPGB_RD_PULLUP, 8'h70);
      // key-return flag, expansion kept off
      wrt(1, 4'h4, 1'b0, 3'h0, 8'hFF);
      ext_val[1] <= 8'hFF;
      repeat (8) @(posedge clock);
      clr_flag();
      look("flag", 6'h01, 8'h00);
      ext_val[1] <= 8'hF7;
      repeat (8) @(posedge clock);
      look("flag", 6'h01, 8'h01);
      ext_val[1] <= 8'hFF;
      wrt(0, 4'h4, 1'b1, 3'h0, 8'h01);
      wrt(1, 4'h4, 1'b1, 3'h0, 8'h00);
      repeat (8) @(posedge clock);
      clr_flag();
      look("flag", 6'h01, 8'h00);
      wrt(0, 4'h4, 1'b1, 3'h0, 8'h00);
      repeat (8) @(posedge clock);
      look("flag", 6'h01, 8'h01);
      // expansion takeover
      wrt(1, 4'h4, 1'b0, 3'h0, 8'hFF);
      wrt(2, 4'h4, 1'b0, 3'h0, 8'hFF);
      wrt(1, 4'h5, 1'b0, 3'h0, 8'hFF);
      wrt(1, 4'h6, 1'b0, 3'h0, 8'hBF);
      wrt(0, 4'h6, 1'b0, 3'h0, 8'h40);
      exp_bus <= '{8'hA5, 1'b1, 8'h3C, 1'b0, 1'b1, 1'b0};
      exp_en <= 4'h7;
      repeat (2) @(posedge clock);
      look("oe", 6'd9, 8'hFF);
      look("out", 6'd17, 8'hA5);
      look("pull", 6'd25, 8'hFF);
      look("oe", 6'd10, 8'hFF);
      look("out", 6'd18, 8'h3C);
      look("oe", 6'd11, 8'hF0);
      look("out", 6'd19, 8'h60);
      exp_bus <= '{8'hA5, 1'b0, 8'h3C, 1'b0, 1'b1, 1'b0};
      exp_en <= 4'hF;
      ext_val[1] <= 8'h3C;
      ext_val[3] <= 8'hBF;
      repeat (8) @(posedge clock);
      look("ad_in", 6'h02, 8'h3C);
      look("wait", 6'h03, 8'h00);
      look("oe", 6'd11, 8'hB0);
      // alternate outputs on port 3
      exp_en <= 4'h0;
      wrt(0, 4'h3, 1'b0, 3'h0, 8'h00);
      wrt(1, 4'h3, 1'b0, 3'h0, 8'h00);
      alt_en[0] <= 8'hFF;
      alt_out[0] <= 8'hFF;
      repeat (2) @(posedge clock);
      look("out", 6'd16, 8'h7C);
      // input-only port and unmapped select
      seed = xs(seed);
      port1_in <= seed[7:0];
      repeat (8) @(posedge clock);
      rd(4'h1, MPGB_RD_PORT, seed[7:0]);
      rd(4'h1, MPGB_RD_DIR, 8'h00);
      rd(4'h2, MPGB_RD_PORT, 8'h00);
      // released pins held by enabled pull-ups
      wrt(1, 4'h7, 1'b0, 3'h0, 8'hFF);
      wrt(2, 4'h7, 1'b0, 3'h0, 8'hFF);
      ext_en[4] <= 8'h00;
      repeat (8) @(posedge clock);
      look("pull", 6'd28, 8'h3F);
      look("alt_in", 6'd36, 8'h3F);
      repeat (2) @(posedge clock);
      finish_test();
   end
endmodule
`default_nettype wire
